// ==== bench/lgtr_circuit.sv ====
// Model of the surrounding circuit that takes the module outputs at each tick
`timescale 1ns/1ps
module lgtr_circuit #(
  parameter int unsigned IO_COUNT = 8
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // From the block
  input  wire logic                tick_out,
  input  wire logic [IO_COUNT-1:0] module_out,
  // Last value taken
  output logic [IO_COUNT-1:0]      taken_r
);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      taken_r <= '0;
    end else if (tick_out) begin
      taken_r <= module_out;
    end
  end
endmodule : lgtr_circuit

// ==== bench/lgtr_top_assertions.sv ====
// Port-level checker for the logic gate and timer relay top
`timescale 1ns/1ps
module lgtr_chk #(
  parameter int unsigned IO_COUNT = 8,
  parameter int unsigned TIMERS   = 2
) (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        arst_n,
  // Watched ports
  input wire logic [IO_COUNT-1:0]         module_in,
  input wire logic [IO_COUNT-1:0]         module_out,
  input wire lgtr_pkg::lgtr_gate_in_type  gate_in,
  input wire lgtr_pkg::lgtr_gate_out_type gate_out,
  input wire logic [TIMERS-1:0]           timer_out,
  input wire logic                        latch_on_input,
  input wire logic                        latch_hold_off_input,
  input wire logic                        latch_out,
  input wire lgtr_pkg::lgtr_timer_in_type pulse_ctl,
  input wire logic                        pulse_out,
  input wire logic                        tick_out
);
  // Open pins read high for the AND family, low for the OR family
  logic [lgtr_pkg::GATE_INPUTS-1:0] hi_w;
  logic [lgtr_pkg::GATE_INPUTS-1:0] lo_w;
  assign hi_w = gate_in.level | ~gate_in.connected;
  assign lo_w = gate_in.level & gate_in.connected;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  mod_pass_a: assert property (tick_out |-> module_out == $past(module_in))
    else $error("module outputs differ from sampled inputs");
  and_eval_a: assert property (tick_out |-> gate_out.and_out == &$past(hi_w))
    else $error("and output wrong");
  nand_eval_a: assert property (tick_out |-> gate_out.nand_out == !(&$past(hi_w)))
    else $error("nand output wrong");
  or_eval_a: assert property (tick_out |-> gate_out.or_out == |$past(lo_w))
    else $error("or output wrong");
  nor_eval_a: assert property (tick_out |-> gate_out.nor_out == !(|$past(lo_w)))
    else $error("nor output wrong");
  xor_eval_a: assert property (tick_out |-> gate_out.xor_out == ^$past(lo_w))
    else $error("xor output wrong");
  not_eval_a: assert property (tick_out |-> gate_out.not_out == !$past(lo_w[0]))
    else $error("inverter output wrong");
  // Only the first cycle after a tick can see the previous result through $past
  edge_and_a: assert property (tick_out && gate_out.and_edge_out |->
    gate_out.and_out && !$past(gate_out.and_out)) else $error("and edge without a rise");
  hold_between_a: assert property (!tick_out |-> $stable(gate_out) && $stable(timer_out)
    && $stable(latch_out) && $stable(pulse_out)) else $error("output moved between ticks");
  latch_clear_a: assert property (tick_out && $past(latch_hold_off_input) |-> !latch_out)
    else $error("latch not cleared");
  latch_set_a: assert property (tick_out && $past(latch_on_input)
    && !$past(latch_hold_off_input) |-> latch_out) else $error("latch not set");
  pulse_clear_a: assert property (tick_out && $past(pulse_ctl.hold_off) |-> !pulse_out)
    else $error("pulse relay not cleared");
  cover property (gate_out.and_edge_out);
  cover property ($rose(timer_out[0]));
  cover property ($rose(latch_out));
  cover property ($rose(pulse_out));
endmodule : lgtr_chk

bind lgtr_top lgtr_chk #(.IO_COUNT(IO_COUNT), .TIMERS(TIMERS)) u_lgtr_chk (
  .core_clk(core_clk), .arst_n(arst_n), .module_in(module_in), .module_out(module_out),
  .gate_in(gate_in), .gate_out(gate_out), .timer_out(timer_out),
  .latch_on_input(latch_on_input), .latch_hold_off_input(latch_hold_off_input),
  .latch_out(latch_out), .pulse_ctl(pulse_ctl), .pulse_out(pulse_out), .tick_out(tick_out));

// ==== bench/tb_lgtr_top.sv ====
// Self-checking bench for the logic gate and timer relay top
`timescale 1ns/1ps
module tb_lgtr_top;
  logic                                   core_clk;
  logic                                   arst_n;
  logic [7:0]                             module_in;
  logic [7:0]                             module_out;
  logic [7:0]                             taken;
  lgtr_pkg::lgtr_gate_in_type             gate_in;
  lgtr_pkg::lgtr_gate_out_type            gate_out;
  lgtr_pkg::lgtr_mode_type [1:0]          timer_mode;
  logic [1:0][10:0]                       timer_on_ticks;
  logic [1:0][10:0]                       timer_off_ticks;
  lgtr_pkg::lgtr_timer_in_type [1:0]      timer_ctl;
  logic [1:0]                             timer_out;
  logic                                   latch_on_input;
  logic                                   latch_hold_off_input;
  logic                                   latch_out;
  lgtr_pkg::lgtr_timer_in_type            pulse_ctl;
  logic                                   pulse_out;
  logic                                   tick_out;
  int                                     n_errors;
  int                                     total_checks;
  int                                     cycles;

  // Short tick so the delay tables run in a few hundred cycles
  lgtr_top #(.IO_COUNT(8), .TIMERS(2), .TICK_CYCLES(4), .W(11)) u_lgtr_top (
    .core_clk(core_clk), .arst_n(arst_n), .module_in(module_in), .module_out(module_out),
    .gate_in(gate_in), .gate_out(gate_out), .timer_mode(timer_mode),
    .timer_on_ticks(timer_on_ticks), .timer_off_ticks(timer_off_ticks),
    .timer_ctl(timer_ctl), .timer_out(timer_out), .latch_on_input(latch_on_input),
    .latch_hold_off_input(latch_hold_off_input), .latch_out(latch_out),
    .pulse_ctl(pulse_ctl), .pulse_out(pulse_out), .tick_out(tick_out));
  lgtr_circuit #(.IO_COUNT(8)) u_lgtr_circuit (
    .core_clk(core_clk), .arst_n(arst_n), .tick_out(tick_out),
    .module_out(module_out), .taken_r(taken));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_gate(input lgtr_pkg::lgtr_gate_out_type exp);
    total_checks++;
    if (gate_out !== exp) begin
      n_errors++;
      $display("CHECK FAILED gate_out expected %h seen %h", exp, gate_out);
    end
  endtask : chk_gate

  // Returns at the falling edge where the fresh evaluation is visible
  task automatic wait_tick();
    int k;
    k = 0;
    @(negedge core_clk);
    while (tick_out !== 1'b1 && k < 10) begin
      @(negedge core_clk);
      k++;
    end
    chk_val("tick_out", 16'h0001, {15'h0000, tick_out});
  endtask : wait_tick

  task automatic test_gates();
    logic [7:0] tbl [8] = '{8'h0F, 8'hFF, 8'hFF, 8'h7F, 8'h30, 8'h1E, 8'h5F, 8'hA5};
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] prev;
    logic [7:0] last;
    prev = 4'hF;
    last = 8'h00;
    for (int i = 0; i < 8; i++) begin
      gate_in = tbl[i];
      module_in = ~tbl[i];
      wait_tick();
      hi = tbl[i][7:4] | ~tbl[i][3:0];
      lo = tbl[i][7:4] & tbl[i][3:0];
      chk_gate({&hi, &hi & ~&prev, ~&hi, ~&hi & &prev, |lo, ~|lo, ^lo, ~lo[0]});
      chk_val("module_out", {8'h00, ~tbl[i]}, {8'h00, module_out});
      chk_val("taken", {8'h00, last}, {8'h00, taken});
      prev = hi;
      last = ~tbl[i];
    end
  endtask : test_gates

  // Drives every relay with the same trigger and hold tables, one bit per tick
  task automatic run(input int sel, input lgtr_pkg::lgtr_mode_type m, input int n,
                     input logic [15:0] trg, input logic [15:0] hld, input logic [15:0] exp);
    timer_mode[0] = m;
    timer_mode[1] = m;
    for (int i = -2; i < n; i++) begin
      timer_ctl = (i < 0) ? 4'h5 : {2{trg[i], hld[i]}};
      pulse_ctl = (i < 0) ? 2'h1 : {trg[i], hld[i]};
      latch_on_input = (i < 0) ? 1'b0 : trg[i];
      latch_hold_off_input = (i < 0) ? 1'b1 : hld[i];
      wait_tick();
      if (i >= 0 && sel == 0) chk_val("timer_out", {14'h0000, {2{exp[i]}}}, {14'h0000, timer_out});
      if (i >= 0 && sel == 1) chk_val("latch_out", {15'h0000, exp[i]}, {15'h0000, latch_out});
      if (i >= 0 && sel == 2) chk_val("pulse_out", {15'h0000, exp[i]}, {15'h0000, pulse_out});
    end
  endtask : run

  task automatic test_on_delay();
    run(0, lgtr_pkg::MODE_ON_DELAY, 9, 16'h006F, 16'h0000, 16'h0008);
  endtask : test_on_delay

  task automatic test_off_delay();
    run(0, lgtr_pkg::MODE_OFF_DELAY, 11, 16'h0109, 16'h0400, 16'h037F);
  endtask : test_off_delay

  task automatic test_on_off();
    run(0, lgtr_pkg::MODE_ON_OFF_DELAY, 13, 16'h01EF, 16'h0000, 16'h0FF8);
  endtask : test_on_off

  task automatic test_retentive();
    run(0, lgtr_pkg::MODE_RETENTIVE_ON, 6, 16'h0005, 16'h0020, 16'h0018);
  endtask : test_retentive

  task automatic test_wipe();
    run(0, lgtr_pkg::MODE_WIPE_LEVEL, 8, 16'h005F, 16'h0000, 16'h0047);
    run(0, lgtr_pkg::MODE_WIPE_EDGE, 7, 16'h0005, 16'h0000, 16'h001F);
  endtask : test_wipe

  task automatic test_latch_pulse();
    run(1, lgtr_pkg::MODE_ON_DELAY, 5, 16'h0009, 16'h000C, 16'h0003);
    run(2, lgtr_pkg::MODE_ON_DELAY, 7, 16'h0035, 16'h0020, 16'h0013);
  endtask : test_latch_pulse

  // A delay set past the ceiling must behave exactly like the ceiling itself
  task automatic test_clamp();
    int k;
    k = 0;
    timer_mode[0] = lgtr_pkg::MODE_ON_DELAY;
    timer_mode[1] = lgtr_pkg::MODE_ON_DELAY;
    timer_on_ticks = {11'h7FF, 11'h3E8};
    timer_ctl = 4'hA;
    wait_tick();
    while (timer_out[1] !== 1'b1 && k < 1100) begin
      wait_tick();
      k++;
    end
    chk_val("clamp_ticks", 16'(lgtr_pkg::DELAY_MAX_TICKS + 1), 16'(k));
    chk_val("timer_out", 16'h0003, {14'h0000, timer_out});
  endtask : test_clamp

  initial begin
    arst_n = 1'b0;
    module_in = 8'h00;
    gate_in = 8'h00;
    timer_mode[0] = lgtr_pkg::MODE_ON_DELAY;
    timer_mode[1] = lgtr_pkg::MODE_ON_DELAY;
    timer_on_ticks = {11'h002, 11'h002};
    timer_off_ticks = {11'h002, 11'h002};
    timer_ctl = 4'h0;
    latch_on_input = 1'b0;
    latch_hold_off_input = 1'b0;
    pulse_ctl = 2'h0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    wait_tick();
    test_gates();
    test_on_delay();
    test_off_delay();
    test_on_off();
    test_retentive();
    test_wipe();
    test_latch_pulse();
    test_clamp();
    report_and_stop();
  end
endmodule : tb_lgtr_top

// ==== hdl/lgtr_gates.sv ====
// Multi-input logic gates, level and edge evaluated
`timescale 1ns/1ps
module lgtr_gates #(
  parameter int unsigned N = lgtr_pkg::GATE_INPUTS
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  // Evaluation tick
  input  wire logic                       tick,
  // Operands
  input  wire lgtr_pkg::lgtr_gate_in_type gate_in,
  // Results, registered
  output lgtr_pkg::lgtr_gate_out_type     gate_out
);

  logic [N-1:0] hi_fill;
  logic [N-1:0] lo_fill;
  logic [N-1:0] hi_prev_r;

  // ---------------------------------------------------------------------------
  // Unconnected inputs default per gate family
  // ---------------------------------------------------------------------------
  assign hi_fill = gate_in.level | ~gate_in.connected;
  assign lo_fill = gate_in.level & gate_in.connected;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_prev_r <= '1;
    end else if (tick) begin
      hi_prev_r <= hi_fill;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_out <= '0;
    end else if (tick) begin
      gate_out.and_out       <= &hi_fill;
      gate_out.and_edge_out  <= (&hi_fill) & ~(&hi_prev_r);
      gate_out.nand_out      <= ~(&hi_fill);
      gate_out.nand_edge_out <= ~(&hi_fill) & (&hi_prev_r);
      gate_out.or_out        <= |lo_fill;
      gate_out.nor_out       <= ~(|lo_fill);
      gate_out.xor_out       <= ^lo_fill;
      gate_out.not_out       <= ~lo_fill[0];
    end
  end

endmodule : lgtr_gates

// ==== hdl/lgtr_timer.sv ====
// One configurable delay timer relay
`timescale 1ns/1ps
module lgtr_timer #(
  parameter int unsigned W = lgtr_pkg::DELAY_W
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  // Evaluation tick
  input  wire logic                        tick,
  // Configuration
  input  wire lgtr_pkg::lgtr_mode_type     mode,
  input  wire logic [W-1:0]                on_ticks,
  input  wire logic [W-1:0]                off_ticks,
  // Control
  input  wire lgtr_pkg::lgtr_timer_in_type ctl,
  // Result
  output logic                             function_output
);

  logic         trig_prev_r;
  logic         running_r;
  logic [W-1:0] count_r;
  logic         rise;
  logic         fall;
  logic         done_on;
  logic         done_off;

  assign rise     = ctl.trigger & ~trig_prev_r;
  assign fall     = ~ctl.trigger & trig_prev_r;
  assign done_on  = running_r && (count_r >= on_ticks);
  assign done_off = running_r && (count_r >= off_ticks);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_prev_r <= 1'b0;
    end else if (tick) begin
      trig_prev_r <= ctl.trigger;
    end
  end

  // ---------------------------------------------------------------------------
  // Counter and output per mode
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      running_r       <= 1'b0;
      count_r         <= '0;
      function_output <= 1'b0;
    end else if (tick) begin
      if (running_r) begin
        count_r <= count_r + 1'b1;
      end
      case (mode)
        lgtr_pkg::MODE_ON_DELAY: begin
          if (!ctl.trigger) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end else if (rise) begin
            running_r <= 1'b1;
            count_r   <= '0;
          end else if (done_on) begin
            running_r       <= 1'b0;
            function_output <= 1'b1;
          end
        end
        lgtr_pkg::MODE_OFF_DELAY: begin
          if (ctl.hold_off) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end else if (ctl.trigger) begin
            running_r       <= 1'b0;
            function_output <= 1'b1;
          end else if (fall) begin
            running_r <= 1'b1;
            count_r   <= '0;
          end else if (done_off) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end
        end
        lgtr_pkg::MODE_ON_OFF_DELAY: begin
          if (rise || fall) begin
            running_r <= (ctl.trigger != function_output);
            count_r   <= '0;
          end else if (ctl.trigger && done_on) begin
            running_r       <= 1'b0;
            function_output <= 1'b1;
          end else if (!ctl.trigger && done_off) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end
        end
        lgtr_pkg::MODE_RETENTIVE_ON: begin
          if (ctl.hold_off) begin
            running_r       <= 1'b0;
            count_r         <= '0;
            function_output <= 1'b0;
          end else if (rise && !running_r && !function_output) begin
            running_r <= 1'b1;
            count_r   <= '0;
          end else if (done_on) begin
            running_r       <= 1'b0;
            function_output <= 1'b1;
          end
        end
        lgtr_pkg::MODE_WIPE_LEVEL: begin
          if (!ctl.trigger) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end else if (rise) begin
            running_r       <= 1'b1;
            count_r         <= '0;
            function_output <= 1'b1;
          end else if (done_on) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end
        end
        lgtr_pkg::MODE_WIPE_EDGE: begin
          if (rise) begin
            running_r       <= 1'b1;
            count_r         <= '0;
            function_output <= 1'b1;
          end else if (done_on) begin
            running_r       <= 1'b0;
            function_output <= 1'b0;
          end
        end
        default: begin
          running_r       <= 1'b0;
          function_output <= 1'b0;
        end
      endcase
    end
  end

endmodule : lgtr_timer

// ==== hdl/lgtr_top.sv ====
// Digital logic module: gates, timer relays, latch and pulse relay
//
// Functional notes
// - AND output high only when all inputs high; open inputs high.
// - Unconnected AND-family inputs read as logic_one.
// - Edge AND pulses when all high now and some low last tick.
// - NAND low only when all inputs high; open inputs high.
// - Edge NAND pulses when some low now and all high last tick.
// - OR high when any input high; open inputs low.
// - NOR high only when all inputs low; open inputs low.
// - XOR high when an odd number of inputs are high; open inputs low.
// - Inverter outputs the complement of its input.
// - Delays configurable 0 to 100 s, default 3 s; DELAY_DEF_TICKS is unused, delays come only from the ports.
// - On delay sets output after full high time; low trigger clears.
// - Off delay sets output at once; falling trigger starts delay.
// - New high-low trigger cycle restarts the off delay.
// - Hold-off clears off delay timer and output early.
// - On/off delay; a running delay clears if trigger reverts.
// - Retentive on delay ignores trigger changes; only hold-off clears.
// - Latch sets on latch_on, clears on hold_off, otherwise holds.
// - Pulse relay toggles on trigger rise; hold-off returns it low.
// - Wiping relay pulses from rise; falls at expiry or trigger low.
// - Edge wiping relay pulses from rise; a new rise retriggers.
// - Retrigger restarts time while output stays high.
// - Module offers 8 or 16 inputs and outputs.
`timescale 1ns/1ps
module lgtr_top #(
  parameter int unsigned IO_COUNT    = lgtr_pkg::IO_COUNT_SMALL,
  parameter int unsigned TIMERS      = 2,
  parameter int unsigned TICK_CYCLES = lgtr_pkg::TICK_CYCLES,
  parameter int unsigned W           = lgtr_pkg::DELAY_W
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  // Module inputs and outputs
  input  wire logic [IO_COUNT-1:0]           module_in,
  output logic [IO_COUNT-1:0]                module_out,
  // Gate operands and results
  input  wire lgtr_pkg::lgtr_gate_in_type    gate_in,
  output lgtr_pkg::lgtr_gate_out_type        gate_out,
  // Timer relays
  input  wire lgtr_pkg::lgtr_mode_type [TIMERS-1:0] timer_mode,
  input  wire logic [TIMERS-1:0][W-1:0]      timer_on_ticks,
  input  wire logic [TIMERS-1:0][W-1:0]      timer_off_ticks,
  input  wire lgtr_pkg::lgtr_timer_in_type [TIMERS-1:0] timer_ctl,
  output logic [TIMERS-1:0]                  timer_out,
  // Latch
  input  wire logic                          latch_on_input,
  input  wire logic                          latch_hold_off_input,
  output logic                               latch_out,
  // Pulse relay
  input  wire lgtr_pkg::lgtr_timer_in_type   pulse_ctl,
  output logic                               pulse_out,
  // Evaluation tick, one cycle wide
  output logic                               tick_out
);

  // ---------------------------------------------------------------------------
  // Cycle tick
  // ---------------------------------------------------------------------------
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0] tick_cnt_r;
  logic          tick;
  logic          pulse_prev_r;
  logic [TIMERS-1:0] t_out;

  // A tick every TICK_CYCLES clocks keeps all evaluation on one cadence
  assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick;
    end
  end

  // ---------------------------------------------------------------------------
  // Module pass-through, sampled on each tick
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      module_out <= '0;
    end else if (tick) begin
      module_out <= module_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Gates
  // ---------------------------------------------------------------------------
  lgtr_gates #(
    .N        (lgtr_pkg::GATE_INPUTS)
  ) u_gates (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (tick),
    .gate_in  (gate_in),
    .gate_out (gate_out)
  );

  // ---------------------------------------------------------------------------
  // Timers; delays are in ticks, clamped to the 100 s ceiling
  // ---------------------------------------------------------------------------
  function automatic logic [W-1:0] clamp_delay(input logic [W-1:0] d);
    clamp_delay = (d > W'(lgtr_pkg::DELAY_MAX_TICKS)) ? W'(lgtr_pkg::DELAY_MAX_TICKS) : d;
  endfunction : clamp_delay

  genvar gi;
  generate
    for (gi = 0; gi < TIMERS; gi++) begin : g_timer
      lgtr_timer #(
        .W               (W)
      ) u_timer (
        .core_clk        (core_clk),
        .arst_n          (arst_n),
        .tick            (tick),
        .mode            (timer_mode[gi]),
        .on_ticks        (clamp_delay(timer_on_ticks[gi])),
        .off_ticks       (clamp_delay(timer_off_ticks[gi])),
        .ctl             (timer_ctl[gi]),
        .function_output (t_out[gi])
      );
    end
  endgenerate

  assign timer_out = t_out;

  // ---------------------------------------------------------------------------
  // Latch and pulse relay
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_out <= 1'b0;
    end else if (tick) begin
      if (latch_hold_off_input) begin
        latch_out <= 1'b0;
      end else if (latch_on_input) begin
        latch_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_prev_r <= 1'b0;
    end else if (tick) begin
      pulse_prev_r <= pulse_ctl.trigger;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_out <= 1'b0;
    end else if (tick) begin
      if (pulse_ctl.hold_off) begin
        pulse_out <= 1'b0;
      end else if (pulse_ctl.trigger && !pulse_prev_r) begin
        pulse_out <= ~pulse_out;
      end
    end
  end

endmodule : lgtr_top

// ==== shared/lgtr_pkg.sv ====
// Package with constants and carriers for the logic gate and timer relay block
package lgtr_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ      = 10_000_000;
  localparam int unsigned DELAY_MAX_S      = 100;
  localparam int unsigned DELAY_DEFAULT_S  = 3;
  localparam int unsigned TICK_TIME_MS     = 100;
  localparam int unsigned TICK_CYCLES      = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int unsigned DELAY_MAX_TICKS  = DELAY_MAX_S * 1000 / TICK_TIME_MS;
  localparam int unsigned DELAY_DEF_TICKS  = DELAY_DEFAULT_S * 1000 / TICK_TIME_MS;
  localparam int unsigned DELAY_W          = 11;

  // ---------------------------------------------------------------------------
  // Module widths and gate fan-in
  // ---------------------------------------------------------------------------
  localparam int unsigned IO_COUNT_SMALL   = 8;
  localparam int unsigned IO_COUNT_LARGE   = 16;
  localparam int unsigned GATE_INPUTS      = 4;

  // ---------------------------------------------------------------------------
  // Timer modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ON_DELAY,
    MODE_OFF_DELAY,
    MODE_ON_OFF_DELAY,
    MODE_RETENTIVE_ON,
    MODE_WIPE_LEVEL,
    MODE_WIPE_EDGE
  } lgtr_mode_type;

  // Per-timer control: trigger and hold-off
  typedef struct packed {
    logic trigger;
    logic hold_off;
  } lgtr_timer_in_type;

  // Multi-input gate operands and connection map
  typedef struct packed {
    logic [GATE_INPUTS-1:0] level;
    logic [GATE_INPUTS-1:0] connected;
  } lgtr_gate_in_type;

  // Gate outputs, one bit per function
  typedef struct packed {
    logic and_out;
    logic and_edge_out;
    logic nand_out;
    logic nand_edge_out;
    logic or_out;
    logic nor_out;
    logic xor_out;
    logic not_out;
  } lgtr_gate_out_type;

endpackage : lgtr_pkg
